// >>> charger_protection_supervisor_bench.sv
`timescale 1ns/1ns
module charger_protection_supervisor_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic slow = 1'b0;
  cps_pkg::cps_cmp_s cmp_tb = '0;
  cps_pkg::cps_cmp_s cmp;
  logic ce, sp, hs, ad, pd, gb, ds, pr, tc, td, ag_o, ag_oe_n, oc;
  logic m_adp, m_pack, m_ag;
  int num_errors = 0;
  int n_compared = 0;

  always #25 clk = ~clk;

  always_comb begin
    cmp = cmp_tb;
    cmp.adp_off = m_adp;
    cmp.pack_off = m_pack;
    cmp.ag_pin = m_ag;
  end

  cps_supervisor #(.QUAL_CYC(20), .BLANK_CYC(8)) uut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_in(cmp),
    .charge_enable(ce), .switching_permit(sp), .high_side_permit(hs),
    .adapter_switch_drive(ad), .pack_switch_drive(pd), .gate_bias_regulator(gb),
    .discharge_sink_en(ds), .precharge_req(pr), .ocl_enable(oc),
    .timer_charge_en(tc), .timer_discharge_en(td),
    .adapter_good_status_o(ag_o), .adapter_good_status_oe_n(ag_oe_n));

  cps_switch_model partner (
    .clk(clk), .slow(slow), .adapter_switch_drive(ad), .pack_switch_drive(pd),
    .ag_oe_n(ag_oe_n), .adp_off(m_adp), .pack_off(m_pack), .ag_pin(m_ag));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic a, input logic e, input string m);
    n_compared++;
    if (a !== e) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_val(ref logic s, input logic v, input int n, input string m);
    int i;
    i = 0;
    n_compared++;
    while (s !== v) begin
      if (i == n) begin
        num_errors++;
        $display("mismatch at %0t: timeout %s", $time, m);
        stop_test();
      end
      @(posedge clk);
      #1;
      i++;
    end
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_chk(input logic [3:0] a, input logic [7:0] k, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    n_compared++;
    if ((reg_rdata & k) !== e) begin
      num_errors++;
      $display("mismatch at %0t: read %h got %h", $time, a, reg_rdata);
    end
  endtask

  always @(negedge clk) begin
    if (!reset && ad === 1'b1 && pd === 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: both switches on", $time);
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    pause(1);
    check(gb, 1'b0, "bias at reset");
    check(td, 1'b1, "timer sink at reset");
    check(ag_oe_n, 1'b1, "status at reset");
    check(ag_o, 1'b0, "status data level");
    check(oc, 1'b0, "limiter at reset");
    reg_write(4'h8, 8'h03);
    reg_chk(4'h0, 8'hFF, 8'h00);
    reg_chk(4'h8, 8'hFF, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_supply_undervoltage_lockout;
    @(posedge clk);
    cmp_tb.det_on <= 1'b1;
    cmp_tb.det_good <= 1'b1;
    cmp_tb.therm_cool <= 1'b1;
    pause(30);
    check(gb, 1'b0, "bias in lockout");
    check(ad, 1'b0, "adapter in lockout");
    check(pd, 1'b0, "pack in lockout");
    $display("test lockout done");
  endtask

  task automatic t_insert;
    reg_write(4'h0, 8'h01);
    @(posedge clk);
    cmp_tb.supply_ok <= 1'b1;
    wait_val(gb, 1'b1, 10, "bias");
    pause(5);
    check(ag_oe_n, 1'b1, "early status");
    wait_val(ag_oe_n, 1'b0, 40, "status");
    check(ad, 1'b0, "adapter before status");
    wait_val(ad, 1'b1, 20, "adapter on");
    check(ce, 1'b1, "charging");
    check(oc, 1'b1, "limiter armed");
    check(ds, 1'b1, "sink while charging");
    reg_chk(4'h4, 8'hC0, 8'h40);
    $display("test insert done");
  endtask

  task automatic t_ovp;
    @(posedge clk);
    slow <= 1'b1;
    cmp_tb.ovp <= 1'b1;
    wait_val(ad, 1'b0, 6, "ovp adapter off");
    check(ce, 1'b0, "ovp charge");
    check(oc, 1'b0, "limiter idle");
    check(ds, 1'b0, "sink idle");
    wait_val(pd, 1'b1, 10, "ovp pack on");
    reg_chk(4'h4, 8'h01, 8'h01);
    @(posedge clk);
    cmp_tb.ovp <= 1'b0;
    wait_val(ad, 1'b1, 40, "ovp resume");
    $display("test ovp done");
  endtask

  task automatic t_limits;
    wait_val(sp, 1'b1, 6, "switching");
    @(posedge clk);
    cmp_tb.therm_hot <= 1'b1;
    cmp_tb.therm_cool <= 1'b0;
    wait_val(sp, 1'b0, 6, "hot");
    @(posedge clk);
    cmp_tb.therm_hot <= 1'b0;
    pause(10);
    check(sp, 1'b0, "thermal hold");
    @(posedge clk);
    cmp_tb.therm_cool <= 1'b1;
    wait_val(sp, 1'b1, 6, "cooled");
    @(posedge clk);
    cmp_tb.pack_ov_hi <= 1'b1;
    cmp_tb.pack_ov_lo <= 1'b1;
    wait_val(sp, 1'b0, 6, "pack ov");
    check(hs, 1'b0, "pack ov high side");
    @(posedge clk);
    cmp_tb.pack_ov_hi <= 1'b0;
    pause(10);
    check(hs, 1'b0, "pack ov hold");
    @(posedge clk);
    cmp_tb.pack_ov_lo <= 1'b0;
    wait_val(hs, 1'b1, 6, "pack ov clear");
    @(posedge clk);
    cmp_tb.chg_oc <= 1'b1;
    wait_val(hs, 1'b0, 6, "overcurrent");
    @(posedge clk);
    cmp_tb.chg_oc <= 1'b0;
    wait_val(hs, 1'b1, 6, "overcurrent clear");
    $display("test limits done");
  endtask

  task automatic t_learn;
    @(posedge clk);
    cmp_tb.pack_short <= 1'b1;
    wait_val(pr, 1'b1, 6, "precharge");
    reg_chk(4'h4, 8'h04, 8'h04);
    @(posedge clk);
    cmp_tb.pack_short <= 1'b0;
    wait_val(pr, 1'b0, 6, "full current");
    reg_write(4'h0, 8'h03);
    wait_val(pd, 1'b1, 20, "learn pack");
    @(posedge clk);
    cmp_tb.pack_short <= 1'b1;
    wait_val(ad, 1'b1, 20, "learn short");
    @(posedge clk);
    cmp_tb.pack_short <= 1'b0;
    wait_val(pd, 1'b1, 20, "learn recover");
    reg_write(4'h0, 8'h01);
    wait_val(ad, 1'b1, 20, "learn exit");
    $display("test learn done");
  endtask

  task automatic t_overpower;
    @(posedge clk);
    cmp_tb.ilim <= 1'b1;
    cmp_tb.tmr_over <= 1'b1;
    wait_val(tc, 1'b1, 6, "timer charge");
    check(td, 1'b0, "timer sink off");
    @(posedge clk);
    cmp_tb.tmr_over <= 1'b0;
    pause(6);
    check(ad, 1'b1, "blanking");
    pause(8);
    @(posedge clk);
    cmp_tb.tmr_over <= 1'b1;
    wait_val(ad, 1'b0, 6, "latch off");
    check(ce, 1'b0, "latch charge");
    wait_val(pd, 1'b1, 10, "latch pack");
    reg_chk(4'h4, 8'h08, 8'h08);
    @(posedge clk);
    cmp_tb.tmr_over <= 1'b0;
    cmp_tb.ilim <= 1'b0;
    wait_val(td, 1'b1, 6, "timer sink");
    pause(20);
    check(ad, 1'b0, "latch holds");
    @(posedge clk);
    cmp_tb.det_good <= 1'b0;
    cmp_tb.sense_low <= 1'b1;
    pause(5);
    @(posedge clk);
    cmp_tb.det_good <= 1'b1;
    pause(40);
    check(ag_oe_n, 1'b0, "requalified");
    check(ad, 1'b0, "interlock stuck");
    @(posedge clk);
    cmp_tb.sense_low <= 1'b0;
    wait_val(ad, 1'b1, 60, "latch cleared");
    $display("test overpower done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_supply_undervoltage_lockout();
    t_insert();
    t_ovp();
    t_limits();
    t_learn();
    t_overpower();
    stop_test();
  end
endmodule

// >>> cps_consts.svh
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH
// Overview of operation
// [R1] Input overvoltage: stop charging, adapter switch off, pack switch on.
// [R2] Overvoltage does not latch; operation resumes once it clears.
// [R3] Supply below 5 V: bias and both gate drives stay inactive.
// [R4] Sense node low with supply good blocks adapter switch turn-on.
// [R5] Pack above 104% stops switching; high side blocked until below 102%.
// [R6] Pack discharge sink enabled only while charging.
// [R7] Pack short flags status and requests one-eighth precharge current.
// [R8] Pack above short threshold plus hysteresis restores full current.
// [R9] Learn cycle with pack short: pack off, adapter on.
// [R10] Pack recovers while learn still high: adapter off, pack back on.
// [R11] Charge current above 145%: high side off, resumes automatically.
// [R12] Above 155 C converter off, stays off until below 135 C.
// [R13] Adapter-good pulled low after detect above 2.4 V plus 700 ms.
// [R14] After 700 ms: adapter-good, pack switch off, then adapter switch on.
// [R15] Input overcurrent limit 1.5x programmed limit, ceiling 100 mV.
// [R16] First 2 ms after adapter turn-on limits current but never latches.
// [R17] Over-power latches only when timer capacitor exceeds 2 V.
// [R18] Limiting charges timer capacitor; otherwise fixed sink discharges it.
// [R19] Over-power fault: no charging, adapter latched off, pack on.
// [R20] Latch clears on detect drop and return, or supply lockout cycle.
// [R21] All comparators synchronised; intervals timed by clock counters.
// [R22] Adapter and pack switches never on together; confirm off first.

// ----------------------------------------
// timing
// ----------------------------------------
`define CPS_CLK_HZ      20000000
`define CPS_QUAL_MS     700
`define CPS_BLANK_MS    2
`define CPS_QUAL_CYC    (`CPS_CLK_HZ / 1000 * `CPS_QUAL_MS)
`define CPS_BLANK_CYC   (`CPS_CLK_HZ / 1000 * `CPS_BLANK_MS)

// ----------------------------------------
// register port
// ----------------------------------------
`define CPS_CTRL_ADDR   4'h0
`define CPS_STAT_ADDR   4'h4
`define CPS_CTRL_RST    8'h00
`define CPS_CTRL_CHG    0
`define CPS_CTRL_LEARN  1
`endif

// >>> cps_pkg.sv
package cps_pkg;
  // power path states, one-hot
  typedef enum logic [3:0] {
    CPS_PACK  = 4'h1,
    CPS_BRK_A = 4'h2,
    CPS_ADPT  = 4'h4,
    CPS_BRK_P = 4'h8
  } cps_path_e;

  // comparator and pin levels, all asynchronous to clk
  typedef struct packed {
    logic ovp;
    logic supply_ok;
    logic det_on;
    logic det_good;
    logic sense_low;
    logic pack_ov_hi;
    logic pack_ov_lo;
    logic pack_short;
    logic chg_oc;
    logic therm_hot;
    logic therm_cool;
    logic ilim;
    logic tmr_over;
    logic adp_off;
    logic pack_off;
    logic ag_pin;
  } cps_cmp_s;

  typedef struct packed {
    logic ag_pin;
    logic adapter_good;
    logic pack_ov_block;
    logic therm_shut;
    logic op_latch;
    logic pack_short;
    logic supply_undervoltage_lockout;
    logic ovp;
  } cps_stat_s;
endpackage

// >>> cps_supervisor.sv
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "cps_consts.svh"
module cps_supervisor #(
  parameter int unsigned QUAL_CYC  = `CPS_QUAL_CYC,
  parameter int unsigned BLANK_CYC = `CPS_BLANK_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // comparator inputs
  input  wire cps_pkg::cps_cmp_s cmp_in,
  // switch and converter controls
  output logic                   charge_enable,
  output logic                   switching_permit,
  output logic                   high_side_permit,
  output logic                   adapter_switch_drive,
  output logic                   pack_switch_drive,
  output logic                   gate_bias_regulator,
  output logic                   discharge_sink_en,
  output logic                   precharge_req,
  output logic                   ocl_enable,
  output logic                   timer_charge_en,
  output logic                   timer_discharge_en,
  // open-drain adapter-good status
  output logic                   adapter_good_status_o,
  output logic                   adapter_good_status_oe_n
);
  localparam int QW = $clog2(QUAL_CYC + 1);
  localparam int BW = $clog2(BLANK_CYC + 1);

  cps_pkg::cps_cmp_s  sync1_q;
  cps_pkg::cps_cmp_s  cmp_q;
  cps_pkg::cps_path_e state_q;
  cps_pkg::cps_path_e state_d;
  logic [7:0]         ctrl_q;
  logic [QW-1:0]      qual_q;
  logic [BW-1:0]      blank_q;
  logic               qual_done;
  logic               armed;
  logic               op_latch_q;
  logic               therm_q;
  logic               povb_q;
  logic               learn;
  logic               want_adp;
  logic               adp_on;
  logic               chg_ok;
  cps_pkg::cps_stat_s stat;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= '0;
      cmp_q   <= '0;
    end else begin
      sync1_q <= cmp_in; // [R21]
      cmp_q   <= sync1_q;
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `CPS_CTRL_RST;
    end else if (reg_wr && reg_addr == `CPS_CTRL_ADDR) begin
      ctrl_q <= reg_wdata;
    end
  end

  always_comb begin
    stat.ag_pin        = cmp_q.ag_pin;
    stat.adapter_good  = cmp_q.det_good && qual_done;
    stat.pack_ov_block = povb_q;
    stat.therm_shut    = therm_q;
    stat.op_latch      = op_latch_q;
    stat.pack_short    = cmp_q.pack_short;
    stat.supply_undervoltage_lockout          = !cmp_q.supply_ok;
    stat.ovp           = cmp_q.ovp;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == `CPS_CTRL_ADDR) begin
      reg_rdata <= ctrl_q;
    end else if (reg_rd && reg_addr == `CPS_STAT_ADDR) begin
      reg_rdata <= stat;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // adapter qualification and blanking timers
  // ----------------------------------------
  assign qual_done = (qual_q == QW'(QUAL_CYC));
  assign armed     = (blank_q == BW'(BLANK_CYC));

  always_ff @(posedge clk) begin
    if (reset || !cmp_q.det_good || !cmp_q.supply_ok) begin
      qual_q <= '0;
    end else if (!qual_done) begin
      qual_q <= qual_q + 1'b1; // [R13] [R21]
    end
  end

  // blanking starts with the adapter drive, restarts on every turn-on
  always_ff @(posedge clk) begin
    if (reset || !adapter_switch_drive) begin
      blank_q <= '0;
    end else if (!armed) begin
      blank_q <= blank_q + 1'b1; // [R16] [R21]
    end
  end

  // ----------------------------------------
  // fault latches
  // ----------------------------------------
  // set wins over clear so a fault at the clearing edge is kept
  always_ff @(posedge clk) begin
    if (reset) begin
      op_latch_q <= 1'b0;
    end else if (armed && cmp_q.tmr_over) begin
      op_latch_q <= 1'b1; // [R16] [R17]
    end else if (!cmp_q.det_good || !cmp_q.supply_ok) begin
      op_latch_q <= 1'b0; // [R20]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      therm_q <= 1'b0;
    end else if (cmp_q.therm_hot) begin
      therm_q <= 1'b1; // [R12]
    end else if (cmp_q.therm_cool) begin
      therm_q <= 1'b0; // [R12]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      povb_q <= 1'b0;
    end else if (cmp_q.pack_ov_hi) begin
      povb_q <= 1'b1; // [R5]
    end else if (!cmp_q.pack_ov_lo) begin
      povb_q <= 1'b0; // [R5]
    end
  end

  // ----------------------------------------
  // power path selector
  // ----------------------------------------
  assign learn = ctrl_q[`CPS_CTRL_LEARN];

  // ovp is a level, so the path returns by itself once it clears
  assign want_adp = stat.adapter_good && cmp_q.supply_ok && !cmp_q.ovp // [R1] [R2]
                    && !op_latch_q // [R19]
                    && (!learn || cmp_q.pack_short); // [R9] [R10]

  always_comb begin
    state_d = state_q;
    case (state_q)
      cps_pkg::CPS_PACK: begin
        // interlock thinks pack is still on while sense node is low
        if (want_adp && !cmp_q.sense_low) begin
          state_d = cps_pkg::CPS_BRK_A; // [R4] [R14]
        end
      end
      cps_pkg::CPS_BRK_A: begin
        if (!want_adp) begin
          state_d = cps_pkg::CPS_PACK;
        end else if (cmp_q.pack_off) begin
          state_d = cps_pkg::CPS_ADPT; // [R22] [R14]
        end
      end
      cps_pkg::CPS_ADPT: begin
        if (!want_adp) begin
          state_d = cps_pkg::CPS_BRK_P; // [R1] [R10] [R19]
        end
      end
      cps_pkg::CPS_BRK_P: begin
        if (cmp_q.adp_off) begin
          state_d = cps_pkg::CPS_PACK; // [R22]
        end
      end
      default: begin
        state_d = cps_pkg::CPS_BRK_P;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= cps_pkg::CPS_PACK;
    end else if (!cmp_q.supply_ok) begin
      state_q <= cps_pkg::CPS_BRK_P; // [R3]
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // output drives
  // ----------------------------------------
  assign adp_on = (state_q == cps_pkg::CPS_ADPT) && want_adp;
  assign chg_ok = ctrl_q[`CPS_CTRL_CHG] && adp_on;

  always_ff @(posedge clk) begin
    if (reset) begin
      adapter_switch_drive <= 1'b0;
      pack_switch_drive    <= 1'b0;
      gate_bias_regulator  <= 1'b0;
      ocl_enable           <= 1'b0;
    end else begin
      // drives need the supply; bias follows supply and detect
      gate_bias_regulator  <= cmp_q.supply_ok && cmp_q.det_on; // [R3]
      adapter_switch_drive <= adp_on && cmp_q.supply_ok; // [R3] [R22]
      pack_switch_drive    <= (state_q == cps_pkg::CPS_PACK) && cmp_q.supply_ok; // [R3] [R22]
      // ratio and ceiling are analog; logic only arms the limiter
      ocl_enable           <= adp_on; // [R15]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      charge_enable     <= 1'b0;
      switching_permit  <= 1'b0;
      high_side_permit  <= 1'b0;
      discharge_sink_en <= 1'b0;
      precharge_req     <= 1'b0;
    end else begin
      charge_enable     <= chg_ok; // [R1] [R19]
      switching_permit  <= chg_ok && !therm_q && !povb_q; // [R5] [R12]
      high_side_permit  <= chg_ok && !therm_q && !povb_q && !cmp_q.chg_oc; // [R11]
      discharge_sink_en <= chg_ok; // [R6]
      precharge_req     <= cmp_q.pack_short; // [R7] [R8]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      timer_charge_en    <= 1'b0;
      timer_discharge_en <= 1'b1;
    end else begin
      timer_charge_en    <= cmp_q.ilim && adapter_switch_drive; // [R18]
      timer_discharge_en <= !(cmp_q.ilim && adapter_switch_drive); // [R18]
    end
  end

  // open drain: output held low, enable low pulls the pin
  assign adapter_good_status_o = 1'b0;

  always_ff @(posedge clk) begin
    if (reset) begin
      adapter_good_status_oe_n <= 1'b1;
    end else begin
      adapter_good_status_oe_n <= !stat.adapter_good; // [R13]
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_switch_exclusive: assert property ( // [R22]
    !(adapter_switch_drive && pack_switch_drive))
    else $error("adapter and pack switches on together");

  a_ovp_path_off: assert property ( // [R1]
    cmp_q.ovp |=> !adapter_switch_drive && !charge_enable)
    else $error("overvoltage did not stop charge and adapter");

  a_supply_undervoltage_lockout_drives_off: assert property ( // [R3]
    !cmp_q.supply_ok |=> !adapter_switch_drive && !pack_switch_drive && !gate_bias_regulator)
    else $error("drives active under lockout");

  a_interlock_stuck: assert property ( // [R4]
    state_q == cps_pkg::CPS_PACK && cmp_q.sense_low && cmp_q.supply_ok
    |=> state_q == cps_pkg::CPS_PACK)
    else $error("adapter path started with sense node low");

  a_povb_holds: assert property ( // [R5]
    povb_q && cmp_q.pack_ov_lo |=> !high_side_permit && !switching_permit)
    else $error("high side allowed above lower overvoltage level");

  a_sink_only_chg: assert property ( // [R6]
    discharge_sink_en |-> charge_enable)
    else $error("discharge sink on without charge");

  a_precharge_req: assert property ( // [R7]
    cmp_q.pack_short |=> precharge_req ##0 $past(cmp_q.pack_short, 1))
    else $error("precharge not requested on pack short");

  a_overcur_hs: assert property ( // [R11]
    cmp_q.chg_oc |=> !high_side_permit)
    else $error("high side on during overcurrent");

  a_therm_hold: assert property ( // [R12]
    therm_q && !cmp_q.therm_cool |=> therm_q && !switching_permit)
    else $error("converter resumed before cool threshold");

  a_good_qualified: assert property ( // [R13]
    $fell(adapter_good_status_oe_n) |-> $past(cmp_q.det_good) && $past(qual_done))
    else $error("adapter good asserted before qualification");

  a_blank_no_latch: assert property ( // [R16]
    $rose(op_latch_q) |-> $past(armed) && $past(cmp_q.tmr_over))
    else $error("over-power latched during blanking");

  a_op_action: assert property ( // [R19]
    op_latch_q |=> !adapter_switch_drive && !charge_enable)
    else $error("over-power latch left adapter or charge on");

  a_op_sticky: assert property ( // [R20]
    op_latch_q && cmp_q.det_good && cmp_q.supply_ok |=> op_latch_q)
    else $error("over-power latch cleared without cause");

  a_path_resume: assert property ( // [R2] [R15]
    state_q == cps_pkg::CPS_ADPT && want_adp |=> adapter_switch_drive && ocl_enable)
    else $error("adapter path not driven while wanted");

  a_precharge_clear: assert property ( // [R8]
    !cmp_q.pack_short |=> !precharge_req)
    else $error("precharge request kept after pack recovered");

  a_learn_short_swap: assert property ( // [R9]
    learn && cmp_q.pack_short && want_adp && !cmp_q.sense_low
    && state_q == cps_pkg::CPS_PACK |=> state_q == cps_pkg::CPS_BRK_A)
    else $error("learn cycle kept pack on a shorted pack");

  a_learn_pack_back: assert property ( // [R10]
    learn && !cmp_q.pack_short |=> !adapter_switch_drive)
    else $error("adapter kept on after pack recovered in learn");

  a_overcur_resume: assert property ( // [R11]
    chg_ok && !therm_q && !povb_q && !cmp_q.chg_oc |=> high_side_permit)
    else $error("high side not resumed after overcurrent");

  a_good_drop: assert property ( // [R13]
    !cmp_q.det_good |=> adapter_good_status_oe_n)
    else $error("adapter good held without detect");

  a_pack_before_adp: assert property ( // [R14] [R22]
    $rose(adapter_switch_drive) |-> !pack_switch_drive && $past(cmp_q.pack_off))
    else $error("adapter switch on before pack confirmed off");

  a_adp_before_pack: assert property ( // [R22]
    $rose(pack_switch_drive) |-> !adapter_switch_drive && $past(!adapter_switch_drive))
    else $error("pack switch on before adapter off");

  a_blank_restart: assert property ( // [R16]
    !adapter_switch_drive |=> !armed)
    else $error("latch-off armed without adapter drive");

  a_timer_charge: assert property ( // [R18]
    cmp_q.ilim && adapter_switch_drive |=> timer_charge_en && !timer_discharge_en)
    else $error("timer not charging while limiting");

  c_adapter_on: cover property ($rose(adapter_switch_drive));
  c_op_latch:   cover property ($rose(op_latch_q));
  c_learn_short: cover property (learn && cmp_q.pack_short ##[1:20] adapter_switch_drive);
  c_interlock:  cover property (state_q == cps_pkg::CPS_PACK && cmp_q.sense_low && want_adp);
  c_back_pack:  cover property ($fell(adapter_switch_drive) ##[1:20] pack_switch_drive);
endmodule

// >>> cps_switch_model.sv
`timescale 1ns/1ns
module cps_switch_model (
  // clock and pace
  input  wire logic clk,
  input  wire logic slow,
  // drives from the supervisor
  input  wire logic adapter_switch_drive,
  input  wire logic pack_switch_drive,
  input  wire logic ag_oe_n,
  // confirmations and pin level
  output logic      adp_off,
  output logic      pack_off,
  output logic      ag_pin
);
  // ----------------------------------------
  // gate discharge
  // ----------------------------------------
  logic [2:0] a_sh = 3'h0;
  logic [2:0] p_sh = 3'h0;
  // a slow gate takes three edges to confirm off, so early turn-on would overlap
  always_ff @(posedge clk) begin
    a_sh <= {a_sh[1:0], ~adapter_switch_drive};
    p_sh <= {p_sh[1:0], ~pack_switch_drive};
  end
  assign adp_off  = (slow ? &a_sh : a_sh[0]) & ~adapter_switch_drive;
  assign pack_off = (slow ? &p_sh : p_sh[0]) & ~pack_switch_drive;
  // pull-up on the open-drain status pin
  assign ag_pin   = ag_oe_n ? 1'b1 : 1'b0;
endmodule
